// ---- bench/dual_adc_readout_checker.sv ----
// assertions on the ports of the dual readout block
// assumes the host parks sclk low and keeps it low 550 ns after each fall
`timescale 1ns/10ps
module dual_adc_readout_checker
(
    input wire mclk,
    input wire rst,
    input wire sclk,
    input wire csN,
    input wire sdo,
    input wire sampleHold,
    input wire powerDown,
    input wire convStep,
    input wire frameDone,
    input wire sampleReady
);
    reg [5:0] stepCnt;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // conversion steps since the sample instant
    always @(posedge mclk or posedge rst)
        if (rst)
            stepCnt <= 6'h00;
        else if (sampleHold)
            stepCnt <= 6'h00;
        else if (convStep)
            stepCnt <= stepCnt + 6'h01;
    AST_PD_HIGH: assert property (csN [*5] |-> powerDown)
        else $error("no power-down while deselected");
    AST_PD_LOW: assert property (
        $fell(csN) |-> ##[1:5] !powerDown)
        else $error("still powered down in frame");
    AST_HOLD: assert property ($fell(csN) |-> ##[1:5] sampleHold)
        else $error("no sample instant after select");
    AST_HOLD_ONE: assert property (
        sampleHold |=> !sampleHold [*4])
        else $error("sample instant repeated");
    AST_HOLD_SEL: assert property (sampleHold |-> !csN)
        else $error("sample instant while deselected");
    AST_SDO_IDLE: assert property (csN [*6] |-> !sdo)
        else $error("data line not idle");
    AST_SDO_EDGE: assert property (
        $changed(sdo) && !csN |-> !$past(sclk))
        else $error("data moved while clock high");
    AST_STEP: assert property (
        $rose(sclk) && !csN |-> ##[1:5] convStep)
        else $error("no conversion step");
    AST_STEP_CNT: assert property (frameDone |-> stepCnt == 6'h20)
        else $error("wrong step count in frame");
    AST_DONE_SDO: assert property (frameDone |-> !sdo)
        else $error("data after last bit");
    cover property (sampleHold);
    cover property (frameDone);
    cover property (!sampleReady);
endmodule // dual_adc_readout_checker

bind dual_adc_readout dual_adc_readout_checker chk (.mclk(mclk), .rst(rst),
    .sclk(sclk), .csN(csN), .sdo(sdo), .sampleHold(sampleHold),
    .powerDown(powerDown), .convStep(convStep), .frameDone(frameDone),
    .sampleReady(sampleReady));

// ---- bench/host_serial_model.sv ----
// host serial controller model: drives clock and select, takes data
// assumes the block samples both pins with its own faster clock
`timescale 1ns/10ps
module host_serial_model
(
    input wire sdo,
    output reg sclk,
    output reg csN
);
    // idle: deselected, clock parked low between frames
    initial
    begin
        sclk = 1'b0;
        csN = 1'b1;
    end
    // 32 clocks of 800 ns; long low phase since data lags a fall up to 3 mclk
    // limitation: clock and frame rate sit below the guaranteed ranges
    // so that the 10 MHz sampler can still see every edge
    task frame;
        output [31:0] w;
        integer i;
        begin
            #37 csN = 1'b0;
            #1000;
            for (i = 0; i < 32; i = i + 1)
            begin
                sclk = 1'b1;
                w = {w[30:0], sdo};
                #250 sclk = 1'b0; // 800 ns period
                #550;
            end
            #500 csN = 1'b1;
            #2000; // frame spacing
        end
    endtask
endmodule // host_serial_model

// ---- bench/tb_dual_adc_readout.sv ----
// self-checking bench for the dual readout block
// assumes the host model owns the link pins; bench feeds sample pairs
`timescale 1ns/10ps
module tb_dual_adc_readout;
    reg mclk = 1'b0;
    reg rst = 1'b1;
    reg sampleValid = 1'b0;
    reg [11:0] firstChannel = 12'h000;
    reg [11:0] secondChannel = 12'h000;
    reg [23:0] lfsr = 24'h000663;
    reg [31:0] word;
    wire sclk, csN, sdo, sampleHold, powerDown, convStep, frameDone;
    wire sampleReady;
    integer errors = 0;
    integer checks = 0;
    integer cycles = 0;
    integer i;
    dual_adc_readout dut (.mclk(mclk), .rst(rst), .sclk(sclk), .csN(csN),
        .sdo(sdo), .sampleHold(sampleHold), .powerDown(powerDown),
        .convStep(convStep), .frameDone(frameDone),
        .sampleValid(sampleValid), .sampleReady(sampleReady),
        .firstChannel(firstChannel), .secondChannel(secondChannel));
    host_serial_model host (.sdo(sdo), .sclk(sclk), .csN(csN));
    // 10 MHz system clock
    always #50 mclk = ~mclk;
    // hang guard, far above the ~2350 cycles the run needs
    always @(posedge mclk)
    begin
        cycles = cycles + 1;
        if (cycles == 20000)
        begin
            errors = errors + 1;
            final_report;
        end
    end
    function [23:0] nextLfsr;
        input [23:0] v;
        nextLfsr = {v[22:0], v[23] ^ v[22] ^ v[21] ^ v[16]};
    endfunction
    // nulls ahead of each result, first channel leads
    function [31:0] expFrame;
        input [23:0] p;
        expFrame = {4'h0, p[23:12], 4'h0, p[11:0]};
    endfunction
    task check;
        input [31:0] got;
        input [31:0] exp;
        begin
            checks = checks + 1;
            if (got !== exp)
            begin
                errors = errors + 1;
                $display("Error at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    // offer one pair and hold it until the block takes it
    task push;
        input [23:0] p;
        begin
            @(posedge mclk) #5;
            sampleValid = 1'b1;
            {firstChannel, secondChannel} = p;
            // ready settled now is what the next edge samples
            while (sampleReady !== 1'b1)
            begin
                @(posedge mclk) #5;
            end
            @(posedge mclk) #5;
            sampleValid = 1'b0;
        end
    endtask
    task final_report;
        begin
            $display("checks %0d errors %0d", checks, errors);
            if (errors == 0 && checks > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    // extremes first, then random pairs
    initial
    begin
        repeat (6) @(posedge mclk);
        #5 rst = 1'b0;
        repeat (2) @(posedge mclk);
        push(24'h8007ff);
        push(24'h7ff800);
        repeat (3) @(posedge mclk);
        #5;
        check({31'h0, sampleReady}, 32'h0); // full buffer refuses
        host.frame(word);
        check(word, expFrame(24'h8007ff));
        check({31'h0, sampleReady}, 32'h1); // room again after pop
        check({31'h0, powerDown}, 32'h1);
        host.frame(word);
        check(word, expFrame(24'h7ff800));
        host.frame(word);
        check(word, expFrame(24'h7ff800));
        for (i = 0; i < 5; i = i + 1)
        begin
            repeat (24) lfsr = nextLfsr(lfsr);
            push(lfsr);
            host.frame(word);
            check(word, expFrame(lfsr));
        end
        final_report;
    end
endmodule // tb_dual_adc_readout

// ---- rtl/dual_adc_defs.vh ----
// constants for the dual-channel serial readout block
// assumes mclk at 10 MHz and a host serial clock well below it
`ifndef DUAL_ADC_DEFS_VH
`define DUAL_ADC_DEFS_VH
`define NULL_BITS 4
`define RESULT_BITS 12
`define FRAME_BITS 32
`define SECOND_START 16
`define CLK_PERIOD_NS 100
`define SCLK_MIN_MHZ_X10 16
`define SCLK_MAX_MHZ_X10 64
`define RATE_MIN_KSPS 50
`define RATE_MAX_KSPS 200
`define BUF_DEPTH 2
`endif

// ---- rtl/dual_adc_readout.v ----
// serial readout of a dual-channel 12-bit simultaneous-sampling converter
// assumes serial clock and chip select are asynchronous host pins that
// run well below mclk; digitised samples come in on a valid/ready port
// and that a source may offer a pair at any time; it moves only while sampleReady is high
`timescale 1ns/10ps
`include "dual_adc_defs.vh"

// What this block does
// - each frame is 4 null bits, first result, 4 null bits, second.
// - data changes on falling serial clock, host samples on rising.
// - the serial clock both shifts data and steps the conversion.
// - chip select is active low; high means power-down.
// - a conversion starts at the falling edge of chip select.
// - each result is a signed two's-complement 12-bit value.
// - both channels are sampled at the same instant.
// - one clock, one select and one data line serve both channels.
module dual_adc_readout
(
    input wire mclk,
    input wire rst,
    input wire sclk,
    input wire csN,
    output reg sdo,
    output reg sampleHold,
    output reg powerDown,
    output reg convStep,
    output reg frameDone,
    input wire sampleValid,
    output reg sampleReady,
    input wire [11:0] firstChannel,
    input wire [11:0] secondChannel
);
    // one-hot frame states
    localparam ST_IDLE = 3'b001;
    localparam ST_ACTIVE = 3'b010;
    localparam ST_DONE = 3'b100;

    reg sclkMeta_q;
    reg sclkSync_q;
    reg sclkPrev_q;
    reg csMeta_q;
    reg csSync_q;
    reg csPrev_q;
    reg [2:0] state_q;
    reg [5:0] bitCnt_q;
    reg [23:0] pair_q;
    reg [23:0] shot_q;
    wire bufInReady;
    wire bufOutValid;
    wire [23:0] bufOutData;
    wire sclkFall;
    wire sclkRise;
    wire csFall;
    wire csHigh;
    wire takePair;
    wire takeIn;
    wire sampleReady_d;

    // null bits read as zero, result bits msb first
    function frame_bit;
        input [5:0] idx;
        input [23:0] pair;
        begin
            if (idx < `NULL_BITS)
                frame_bit = 1'b0;
            else if (idx < `SECOND_START)
                frame_bit = pair[23 - (idx - `NULL_BITS)];
            else if (idx < `SECOND_START + `NULL_BITS)
                frame_bit = 1'b0;
            else if (idx < `FRAME_BITS)
                frame_bit = pair[11 - (idx - `SECOND_START - `NULL_BITS)];
            else
                frame_bit = 1'b0;
        end
    endfunction

    // high-to-low step between two synchronised samples
    function went_low;
        input older;
        input newer;
        begin
            went_low = older && !newer;
        end
    endfunction

    // both pins are asynchronous: two flops before any logic looks
    // cost: up to three mclk of lag per edge, so each serial clock
    // phase must last several mclk periods
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            sclkMeta_q <= 1'b0;
            sclkSync_q <= 1'b0;
            sclkPrev_q <= 1'b0;
            csMeta_q <= 1'b1;
            csSync_q <= 1'b1;
            csPrev_q <= 1'b1;
        end
        else
        begin
            sclkMeta_q <= sclk;
            sclkSync_q <= sclkMeta_q;
            sclkPrev_q <= sclkSync_q;
            csMeta_q <= csN;
            csSync_q <= csMeta_q;
            csPrev_q <= csSync_q;
        end
    end

    assign sclkFall = went_low(sclkPrev_q, sclkSync_q);
    assign sclkRise = !sclkPrev_q && sclkSync_q;
    assign csFall = went_low(csPrev_q, csSync_q);
    assign csHigh = csSync_q;
    // a pair is latched at most once per frame, at the select edge when the buffer holds one
    assign takePair = csFall && bufOutValid;

    // a pair moves only when the source sees ready; ready must promise
    // room at the next edge, else a word is dropped into a full buffer
    assign takeIn = sampleValid && sampleReady;
    assign sampleReady_d = !((!bufInReady || (bufOutValid && takeIn))
        && !takePair);

    // sample pair buffer: source stalls while both slots hold data
    sample_buffer u_buf
    (
        .mclk(mclk),
        .rst(rst),
        .inValid(takeIn),
        .inReady(bufInReady),
        .inData({firstChannel, secondChannel}),
        .outValid(bufOutValid),
        .outReady(takePair),
        .outData(bufOutData)
    );

    // frame sequencer driven by edges of the host serial clock
    // select high wins: a cut frame is dropped, never resumed
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            state_q <= ST_IDLE;
            bitCnt_q <= 6'h00;
            shot_q <= 24'h000000;
            pair_q <= 24'h000000;
            sdo <= 1'b0;
            sampleHold <= 1'b0;
            powerDown <= 1'b1;
            convStep <= 1'b0;
            frameDone <= 1'b0;
            sampleReady <= 1'b0;
        end
        else
        begin
            sampleReady <= sampleReady_d;
            convStep <= 1'b0;
            frameDone <= 1'b0;
            sampleHold <= 1'b0;
            powerDown <= csHigh;
            if (takePair)
                pair_q <= bufOutData; // twos complement kept as is
            if (csHigh)
            begin
                // select high ends any frame at once and stops output
                state_q <= ST_IDLE;
                bitCnt_q <= 6'h00;
                sdo <= 1'b0;
            end
            else
            begin
                case (state_q)
                    ST_IDLE:
                    begin
                        if (csFall)
                        begin
                            state_q <= ST_ACTIVE;
                            sampleHold <= 1'b1;
                            bitCnt_q <= 6'h00;
                            sdo <= 1'b0; // first null bit
                            if (bufOutValid)
                                shot_q <= bufOutData;
                            else
                                shot_q <= pair_q; // repeat last pair
                        end
                    end
                    ST_ACTIVE:
                    begin
                        // shift on falling edge only
                        if (sclkFall)
                        begin
                            bitCnt_q <= bitCnt_q + 6'h01;
                            sdo <= frame_bit(bitCnt_q + 6'h01,
                                shot_q);
                            if (bitCnt_q == `FRAME_BITS - 1)
                            begin
                                state_q <= ST_DONE;
                                frameDone <= 1'b1;
                                sdo <= 1'b0;
                            end
                        end
                        if (sclkRise)
                            convStep <= 1'b1;
                    end
                    ST_DONE:
                    begin
                        sdo <= 1'b0; // extra clocks give zeros
                    end
                    default:
                    begin
                        state_q <= ST_IDLE;
                    end
                endcase
            end
        end
    end
endmodule // dual_adc_readout

// ---- rtl/sample_buffer.v ----
// two-entry buffer carrying a sampled pair of results
// assumes both sides are on mclk; valid/ready handshake on each side
`timescale 1ns/10ps
module sample_buffer
(
    input wire mclk,
    input wire rst,
    input wire inValid,
    output wire inReady,
    input wire [23:0] inData,
    output wire outValid,
    input wire outReady,
    output reg [23:0] outData
);
    reg [23:0] slot0_q;
    reg [23:0] slot1_q;
    reg [1:0] count_q;
    wire push;
    wire pop;

    // two slots: head in slot0, tail in slot1
    assign inReady = (count_q != 2'h2);
    assign outValid = (count_q != 2'h0);
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    // read data always comes from a register
    always @*
    begin
        outData = slot0_q;
    end

    // shift on pop so the head stays in slot0
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            slot0_q <= 24'h000000;
            slot1_q <= 24'h000000;
            count_q <= 2'h0;
        end
        else
        begin
            case ({push, pop})
                2'b10:
                begin
                    if (count_q == 2'h0)
                        slot0_q <= inData;
                    else
                        slot1_q <= inData;
                    count_q <= count_q + 2'h1;
                end
                2'b01:
                begin
                    slot0_q <= slot1_q;
                    count_q <= count_q - 2'h1;
                end
                2'b11:
                begin
                    if (count_q == 2'h1)
                        slot0_q <= inData;
                    else
                    begin
                        slot0_q <= slot1_q;
                        slot1_q <= inData;
                    end
                end
                default:
                begin
                    count_q <= count_q;
                end
            endcase
        end
    end
endmodule // sample_buffer
